// ===== verilog/cev_cfg.svh
// Constants of the CAN event and interrupt block
`ifndef CEV_CFG_SVH
`define CEV_CFG_SVH
`define CEV_A_FLG_LO   8'h00
`define CEV_A_FLG_HI   8'h04
`define CEV_A_INFO     8'h08
`define CEV_A_EVT      8'h0c
`define CEV_A_PROTO    8'h10
`define CEV_A_LIMIT    8'h14
`define CEV_A_PTR      8'h18
`define CEV_A_CNT      8'h1c
`define CEV_A_OBJ      8'h80
`define CEV_BIT_INT_EN 3
`define CEV_EVT_RX     0
`define CEV_EVT_TX     1
`define CEV_EVT_FULL   2
`define CEV_THR_PROTO  9'h007
`define CEV_THR_CAN    9'h009
`define CEV_PTR_START  8'h01
`define CEV_DN_LAST    2'h2
`define CEV_DN_FIRST   2'h0
`define CEV_DN_SINGLE  6'h3f
`define CEV_CO_LAST    0
`define CEV_BUF_MAX    256
`define CEV_BUF_MIN    16
`define CEV_NUM_OBJ    32
`define CEV_LIMIT_RST  9'h100
`endif

// ===== verilog/cev_pkg.sv
// Types of the CAN event and interrupt block
package cev_pkg;
  typedef enum logic [1:0] {
    PROTO_CAN,
    PROTO_DEVICENET,
    PROTO_CANOPEN,
    PROTO_OSEK
  } cev_proto_t;

  typedef struct packed {
    logic [4:0] obj;
  } cev_tx_done_t;

  typedef struct packed {
    logic [4:0] obj;
    logic       fragmented;
    logic [7:0] header;
    logic       last_hint;
    logic [3:0] nbytes;
  } cev_rx_frame_t;

  typedef struct packed {
    logic [7:0] data;
  } cev_count_wr_t;
endpackage

// ===== verilog/cev_event_irq.sv
// Message-complete, buffer-full and fragment decode logic with APB registers
//
// Notes on behaviour
// - Single frame completes at frame end; fragmented on last
// - Every good transmitted frame completes its object
// - Object control bit 3 enables its interrupt
// - 32 completion flags in two halves
// - Completion flag sets regardless of enables
// - Rx flag bit 0, Tx flag bit 1
// - Interrupt flag sets with enabled status flag
// - Flags clear on writing one
// - No re-raise from still-set status flags
// - Info bits 4:0 give lowest enabled pending
// - Info bit 5 shows any enabled pending
// - Protocols: full below seven bytes remaining
// - Plain CAN: below nine, no count
// - Full check only after non-final frames
// - Full: write count, pointer to one, interrupt
// - After wrap store from one, no semaphore
// - End writes count since last wrap
// - Buffer at most 256 bytes
// - DeviceNet fragment type and count decode
// - CANopen c bit marks last segment
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cev_cfg.svh"

module cev_event_irq #(
  parameter int BUF_BYTES = `CEV_BUF_MAX
) (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   tx_done_valid,
  input  wire cev_pkg::cev_tx_done_t  tx_done,
  input  wire logic                   rx_frame_valid,
  input  wire cev_pkg::cev_rx_frame_t rx_frame,
  output logic                        count_wr,
  output cev_pkg::cev_count_wr_t      count_wr_data,
  output logic      [7:0]             dma_pointer,
  output logic                        irq_rx_done,
  output logic                        irq_tx_done,
  output logic                        irq_rx_full
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (BUF_BYTES > `CEV_BUF_MAX || BUF_BYTES < `CEV_BUF_MIN) begin : g_chk
    $error("BUF_BYTES out of range");
  end

  // Restart offset and thresholds must fit the smallest buffer
  if (`CEV_PTR_START >= `CEV_BUF_MIN) begin : g_chk_start
    $error("pointer restart outside buffer");
  end

  if (`CEV_THR_CAN >= `CEV_BUF_MIN || `CEV_THR_PROTO >= `CEV_BUF_MIN) begin : g_chk_thr
    $error("full threshold above smallest buffer");
  end

  // Limit reset may not exceed the largest buffer
  if (`CEV_LIMIT_RST > `CEV_BUF_MAX) begin : g_chk_limit
    $error("limit reset above buffer size");
  end

  // Object numbers on the event ports must reach every object
  if (`CEV_NUM_OBJ != (1 << $bits(cev_pkg::cev_tx_done_t))) begin : g_chk_obj
    $error("object count does not match object number width");
  end

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [4:0] lowest_set(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = `CEV_NUM_OBJ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] onehot(input logic [4:0] n);
    return 32'h0000_0001 << n;
  endfunction

  // Wide sum so a pass beyond the buffer top is still seen
  function automatic logic [8:0] add_bytes(input logic [7:0] base, input logic [3:0] n);
    return {1'b0, base} + {5'h00, n};
  endfunction

  function automatic logic [8:0] full_thr(input cev_pkg::cev_proto_t p);
    return (p == cev_pkg::PROTO_CAN) ? `CEV_THR_CAN : `CEV_THR_PROTO;
  endfunction

  function automatic logic dn_last(input logic [7:0] h);
    logic [1:0] kind;
    logic [5:0] count;
    kind  = h[7:6];
    count = h[5:0];
    return kind == `CEV_DN_LAST || (kind == `CEV_DN_FIRST && count == `CEV_DN_SINGLE);
  endfunction

  function automatic logic [8:0] limit_cap(input logic [8:0] v);
    return (v > 9'(BUF_BYTES)) ? 9'(BUF_BYTES) : v;
  endfunction

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Release is synchronous so every flop leaves reset on one edge
  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0]        obj_ctl_q [`CEV_NUM_OBJ];
  logic [31:0]       status_q;
  logic [2:0]        evt_q;
  cev_pkg::cev_proto_t proto_q;
  logic [8:0]        limit_q;
  logic [7:0]        ptr_q;
  logic [7:0]        cnt_q;
  logic [31:0]       int_en;
  logic [31:0]       pend;
  logic [7:0]        info;
  logic              any_pend;
  logic [4:0]        low_obj;

  always_comb begin
    for (int i = 0; i < `CEV_NUM_OBJ; i++) begin
      int_en[i] = obj_ctl_q[i][`CEV_BIT_INT_EN];
    end
  end

  assign pend     = status_q & int_en;
  assign any_pend = |pend;
  assign low_obj  = lowest_set(pend);
  assign info     = {2'h0, any_pend, low_obj};

  // ---------------------------------------------------------------
  // Object window decode
  // ---------------------------------------------------------------
  logic       obj_hit;
  logic [4:0] obj_idx;

  // One aligned word for each object above the fixed registers
  assign obj_hit = paddr >= `CEV_A_OBJ && paddr[1:0] == 2'h0;
  assign obj_idx = paddr[6:2];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic wr_acc;
  logic setup;
  logic mapped;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    mapped = paddr[1:0] == 2'h0 &&
             (paddr >= `CEV_A_OBJ || paddr <= `CEV_A_CNT);
  end

  function automatic logic wr_at(input logic [7:0] a);
    return wr_acc && paddr == a;
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
      prdata  <= 32'h0000_0000;
      // Captured in setup, held through access
      if (obj_hit) begin
        prdata <= {24'h00_0000, obj_ctl_q[obj_idx]};
      end else begin
        unique case (paddr)
          `CEV_A_FLG_LO: prdata <= {16'h0000, status_q[15:0]};
          `CEV_A_FLG_HI: prdata <= {16'h0000, status_q[31:16]};
          `CEV_A_INFO:   prdata <= {24'h00_0000, info};
          `CEV_A_EVT:    prdata <= {29'h0, evt_q};
          `CEV_A_PROTO:  prdata <= {30'h0, proto_q};
          `CEV_A_LIMIT:  prdata <= {23'h0, limit_q};
          `CEV_A_PTR:    prdata <= {24'h00_0000, ptr_q};
          `CEV_A_CNT:    prdata <= {24'h00_0000, cnt_q};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CEV_NUM_OBJ; i++) begin
        obj_ctl_q[i] <= 8'h00;
      end
    end else if (wr_acc && obj_hit) begin
      obj_ctl_q[obj_idx] <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      proto_q <= cev_pkg::PROTO_CAN;
      limit_q <= `CEV_LIMIT_RST;
    end else begin
      if (wr_at(`CEV_A_PROTO)) begin
        proto_q <= cev_pkg::cev_proto_t'(pwdata[1:0]);
      end
      if (wr_at(`CEV_A_LIMIT)) begin
        // Never beyond the buffer size BUF_BYTES
        limit_q <= limit_cap(pwdata[8:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Fragment header decode
  // ---------------------------------------------------------------
  logic rx_last;

  always_comb begin
    rx_last = 1'b1;
    if (rx_frame.fragmented) begin
      unique case (proto_q)
        cev_pkg::PROTO_DEVICENET:
          rx_last = dn_last(rx_frame.header);
        cev_pkg::PROTO_CANOPEN:
          rx_last = rx_frame.header[`CEV_CO_LAST];
        cev_pkg::PROTO_CAN,
        cev_pkg::PROTO_OSEK:
          rx_last = rx_frame.last_hint;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Buffer accounting
  // ---------------------------------------------------------------
  logic [8:0] ptr_next;
  logic [8:0] cnt_next;
  logic [8:0] remain;
  logic [8:0] thr;
  logic       rx_full;
  logic       rx_end;
  logic       is_can;
  logic       rx_close;

  assign is_can   = proto_q == cev_pkg::PROTO_CAN;
  assign ptr_next = add_bytes(ptr_q, rx_frame.nbytes);
  assign cnt_next = add_bytes(cnt_q, rx_frame.nbytes);
  assign remain   = (limit_q > ptr_next) ? limit_q - ptr_next : 9'h000;
  assign thr      = full_thr(proto_q);
  assign rx_end   = rx_frame_valid && rx_last;
  assign rx_full  = rx_frame_valid && !rx_last && remain < thr;
  // Either case restarts the pointer and, outside plain CAN, hands over the count
  assign rx_close = rx_end || rx_full;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= `CEV_PTR_START;
      cnt_q <= 8'h00;
    end else if (rx_close) begin
      // Hardware restart wins over a software pointer move
      ptr_q <= `CEV_PTR_START;
      cnt_q <= 8'h00;
    end else if (rx_frame_valid) begin
      ptr_q <= ptr_next[7:0];
      cnt_q <= cnt_next[7:0];
    end else if (wr_at(`CEV_A_PTR)) begin
      ptr_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_wr      <= 1'b0;
      count_wr_data <= '0;
    end else begin
      // Count goes to location zero, never in plain CAN
      count_wr <= rx_close && !is_can;
      if (rx_close && !is_can) begin
        count_wr_data.data <= cnt_next[7:0];
      end
    end
  end

  assign dma_pointer = ptr_q;

  // ---------------------------------------------------------------
  // Completion status flags
  // ---------------------------------------------------------------
  logic [31:0] set_tx;
  logic [31:0] set_rx;
  logic [31:0] clr_st;

  assign set_tx = tx_done_valid ? onehot(tx_done.obj) : 32'h0;
  assign set_rx = rx_end ? onehot(rx_frame.obj) : 32'h0;

  always_comb begin
    clr_st = 32'h0;
    if (wr_at(`CEV_A_FLG_LO)) begin
      clr_st[15:0] = pwdata[15:0];
    end
    if (wr_at(`CEV_A_FLG_HI)) begin
      clr_st[31:16] = pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 32'h0;
    end else begin
      // Setting wins over a clear in the same cycle
      status_q <= (status_q & ~clr_st) | set_tx | set_rx;
    end
  end

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  logic [2:0] evt_set;
  logic [2:0] evt_clr;

  always_comb begin
    evt_set = 3'h0;
    evt_set[`CEV_EVT_TX]   = |(set_tx & int_en);
    evt_set[`CEV_EVT_RX]   = |(set_rx & int_en);
    evt_set[`CEV_EVT_FULL] = rx_full;
    evt_clr = wr_at(`CEV_A_EVT) ? pwdata[2:0] : 3'h0;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= 3'h0;
    end else begin
      // A new event wins over a same-cycle clear
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  assign irq_rx_done = evt_q[`CEV_EVT_RX];
  assign irq_tx_done = evt_q[`CEV_EVT_TX];
  assign irq_rx_full = evt_q[`CEV_EVT_FULL];

endmodule // cev_event_irq

// ===== verification/cev_event_irq_properties.sv
// Port-level checks of the event and interrupt block
`timescale 1ns/1ps
`include "cev_cfg.svh"
module cev_event_irq_properties #(
  parameter int BUF_BYTES = `CEV_BUF_MAX
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        tx_done_valid,
  input wire logic        rx_frame_valid,
  input wire logic        count_wr,
  input wire logic [7:0]  dma_pointer,
  input wire logic        irq_rx_done,
  input wire logic        irq_tx_done,
  input wire logic        irq_rx_full
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----
  // Event flag sources and clears
  // ----
  logic evt_wr;
  assign evt_wr = psel && penable && pwrite && paddr == `CEV_A_EVT;
  sequence frame_s; rx_frame_valid; endsequence
  sequence wrap_s; frame_s ##1 $rose(irq_rx_full); endsequence
  a_count_cause: assert property (count_wr |-> $past(rx_frame_valid) && dma_pointer == `CEV_PTR_START)
    else $error("count write without frame end");
  a_full_ptr: assert property (wrap_s |-> dma_pointer == `CEV_PTR_START)
    else $error("pointer not reset on buffer full");
  a_full_cause: assert property ($rose(irq_rx_full) |-> $past(rx_frame_valid))
    else $error("buffer full without frame");
  a_tx_cause: assert property ($rose(irq_tx_done) |-> $past(tx_done_valid))
    else $error("tx flag without completion");
  a_rx_cause: assert property ($rose(irq_rx_done) |-> $past(rx_frame_valid))
    else $error("rx flag without frame");
  a_tx_hold: assert property (irq_tx_done && !(evt_wr && pwdata[1]) |=> irq_tx_done)
    else $error("tx request dropped");
  a_tx_release: assert property (evt_wr && pwdata[1] && !tx_done_valid |=> !irq_tx_done)
    else $error("tx flag not cleared");
  a_rx_release: assert property (evt_wr && pwdata[0] && !rx_frame_valid |=> !irq_rx_done)
    else $error("rx flag not cleared");
  a_full_hold: assert property (irq_rx_full && !(evt_wr && pwdata[2]) |=> irq_rx_full)
    else $error("full request dropped");
endmodule // cev_event_irq_properties

bind cev_event_irq cev_event_irq_properties #(.BUF_BYTES(BUF_BYTES)) chk_u (
  .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .tx_done_valid(tx_done_valid), .rx_frame_valid(rx_frame_valid),
  .count_wr(count_wr), .dma_pointer(dma_pointer), .irq_rx_done(irq_rx_done),
  .irq_tx_done(irq_tx_done), .irq_rx_full(irq_rx_full));

// ===== verification/cev_dma_model.sv
// Message DMA model delivering stored receive frames
`timescale 1ns/1ps
module cev_dma_model (
  input  wire logic              core_clk,
  output logic                   rx_frame_valid,
  output cev_pkg::cev_rx_frame_t rx_frame
);
  initial begin
    rx_frame_valid = 1'b0;
    rx_frame = '0;
  end
  // ----
  // Pulse once the last byte is stored
  // ----
  task automatic send(input cev_pkg::cev_rx_frame_t f);
    @(posedge core_clk);
    rx_frame_valid <= 1'b1;
    rx_frame <= f;
    @(posedge core_clk);
    rx_frame_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
endmodule // cev_dma_model

// ===== verification/can_ctl_event_interrupts_bench.sv
// Self-checking bench of the event and interrupt block
`timescale 1ns/1ps
`include "cev_cfg.svh"
module can_ctl_event_interrupts_bench;
  logic                   core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, tx_done_valid = 0;
  logic [7:0]             paddr = '0, dma_pointer;
  logic [31:0]            pwdata = '0, prdata, r, k;
  logic                   pready, pslverr, e, count_wr, irq_rx_done, irq_tx_done, irq_rx_full, rx_frame_valid;
  logic [4:0]             o, p, u, m;
  cev_pkg::cev_tx_done_t  tx_done = '0;
  cev_pkg::cev_rx_frame_t rx_frame;
  cev_pkg::cev_count_wr_t count_wr_data;
  int                     failures = 0, check_count = 0, seed = 32'h70f8;
  logic [31:0]            cq[$];
  always #4 core_clk = ~core_clk;
  cev_event_irq dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_done_valid(tx_done_valid), .tx_done(tx_done), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
    .count_wr(count_wr), .count_wr_data(count_wr_data), .dma_pointer(dma_pointer),
    .irq_rx_done(irq_rx_done), .irq_tx_done(irq_tx_done), .irq_rx_full(irq_rx_full));
  cev_dma_model dma_u (.core_clk(core_clk), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame));
  // ----
  // Tasks
  // ----
  task summarize;
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin failures++; summarize; end
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x); apb(0, a, $random(seed)); chk(r, x); endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, {16'($random(seed)), d[15:0]}); endtask
  task tx(input logic [4:0] n);
    @(posedge core_clk);
    tx_done_valid <= 1; tx_done.obj <= n;
    @(posedge core_clk);
    tx_done_valid <= 0; tx_done.obj <= ~n;
    #1;
  endtask
  task rx(input logic [7:0] h, input logic l, input logic [3:0] n);
    dma_u.send({o, 1'b1, h, l, n});
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // Count writes against the oldest note
  always @(posedge core_clk) if (count_wr === 1'b1) begin
    if (cq.size() == 0) cq.push_back(32'h1ff);
    chk({24'h0, count_wr_data.data}, cq.pop_front());
  end
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1;
    repeat (3) @(posedge core_clk);
    rd(`CEV_A_INFO, 0);
    rd(`CEV_A_LIMIT, 32'h100);
    apb(0, 8'h40, 0); chk({31'h0, e}, 1);
    o = 5'($random(seed)); p = o ^ 5'h10; u = o ^ 5'h08;
    wr({1'b1, o, 2'b00}, 32'h8); wr({1'b1, p, 2'b00}, 32'h8);
    tx(u); chk(irq_tx_done, 0);
    rd(`CEV_A_INFO, 0);
    tx(p); tx(o); chk(irq_tx_done, 1);
    k = (32'h1 << u) | (32'h1 << p) | (32'h1 << o);
    rd(`CEV_A_FLG_LO, k & 32'hffff);
    rd(`CEV_A_FLG_HI, k >> 16);
    m = (o < p) ? o : p;
    rd(`CEV_A_INFO, {26'h1, m});
    wr(`CEV_A_EVT, 32'h2); chk(irq_tx_done, 0);
    repeat (3) @(posedge core_clk);
    #1 chk(irq_tx_done, 0);
    k = 32'h1 << m; wr(`CEV_A_FLG_LO, k & 32'hffff); wr(`CEV_A_FLG_HI, k >> 16);
    rd(`CEV_A_INFO, {26'h1, m ^ 5'h10});
    tx(m); chk(irq_tx_done, 1);
    wr(`CEV_A_FLG_LO, 32'hffff); wr(`CEV_A_FLG_HI, 32'hffff); wr(`CEV_A_EVT, 32'h7);
    wr(`CEV_A_LIMIT, 32'h10); wr(`CEV_A_PROTO, 32'h1);
    rx(8'h00, 0, 8); chk(dma_pointer, 9);
    cq.push_back(12); rx(8'h41, 0, 4); chk(irq_rx_full, 1);
    chk(dma_pointer, 1);
    cq.push_back(3); rx(8'h82, 0, 3); chk(irq_rx_done, 1);
    cq.push_back(2); rx(8'h3f, 0, 2);
    wr(`CEV_A_EVT, 32'h7); wr(`CEV_A_PROTO, 32'h2);
    cq.push_back(14); rx(8'h00, 0, 7); rx(8'h01, 0, 7);
    chk(irq_rx_full, 0);
    wr(`CEV_A_PROTO, 32'h3); cq.push_back(5); rx(8'h00, 1, 5);
    wr(`CEV_A_EVT, 32'h7); wr(`CEV_A_PROTO, 32'h0);
    rx(8'h00, 0, 8); chk(irq_rx_full, 1);
    rx(8'h00, 1, 2); chk(irq_rx_done, 1);
    wr(`CEV_A_PTR, 32'h3); rx(8'h00, 0, 2); chk(dma_pointer, 5);
    rd(`CEV_A_CNT, 2);
    wr(`CEV_A_EVT, 32'h7); wr(`CEV_A_FLG_LO, 32'hffff); wr(`CEV_A_FLG_HI, 32'hffff);
    dma_u.send({u, 1'b0, 8'h41, 1'b0, 4'h3}); repeat (2) @(posedge core_clk);
    #1 chk(dma_pointer, 1);
    chk(irq_rx_done, 0);
    k = 32'h1 << u; rd(`CEV_A_FLG_LO, k & 32'hffff);
    rd(`CEV_A_FLG_HI, k >> 16);
    chk(cq.size(), 0);
    summarize;
  end
endmodule // can_ctl_event_interrupts_bench
